// [shared/emb_params.svh]
// Constants for the external memory bus and breakpoint block.
// Assumes 32-bit classic Wishbone register access at byte addresses.
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
// Register byte offsets
`define EMB_OFS_BRK_CONTROL 8'h00
`define EMB_OFS_BRK_MATCH_ADDR 8'h04
`define EMB_OFS_IRQ_STATUS 8'h08
`define EMB_OFS_IRQ_CLEAR 8'h0C
`define EMB_OFS_IRQ_ENABLE 8'h10
// Field positions of brk_control
`define EMB_BIT_BRK_STATUS 0
`define EMB_BIT_BRK_ENABLE 1
`define EMB_BIT_BRK_PULSE_MODE 2
// Field positions of the interrupt registers
`define EMB_BIT_IRQ_BRK 0
`define EMB_BIT_IRQ_EXT 1
// Reset values
`define EMB_RST_MATCH_ADDR 16'h0000
`define EMB_RST_IRQ_ENABLE 2'h0
// Lowest code address that is fetched outside when on-chip code is selected
`define EMB_EXT_CODE_BASE 16'h4000
// Breakpoint pulse length in core clocks
`define EMB_BRK_PULSE_CLKS 4'h8
`endif

// [shared/emb_pkg.sv]
// Types for the external memory bus and breakpoint block.
// Assumes nothing beyond a SystemVerilog compiler.
package emb_pkg;
	// Kind of cycle the external bus carries
	typedef enum logic [1:0] {EMB_IDLE, EMB_READ, EMB_WRITE, EMB_FETCH} emb_cyc_t;
endpackage : emb_pkg

// [tb/emb_mem_model.sv]
// External code and data memory on the far side of the data pins.
// Assumes pins registered by the block on clk_i; bus has no pull resistor.
`timescale 1ns/1ps
module emb_mem_model (
	input wire logic clk_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] data_i,
	input wire logic oe_i,
	output logic [7:0] data_o
);
	logic [7:0] mem [0:255]; // Byte store indexed by the low address byte
	// Fill with a known pattern so reads are predictable
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = i[7:0] ^ 8'h5A;
		end
	end
	// Capture write data while the block drives the bus
	always @(posedge clk_i) begin
		if (oe_i) begin
			mem[addr_i[7:0]] <= data_i;
		end
	end
	// Wire level: block value while it drives, memory value otherwise
	always_comb begin
		if (oe_i) begin
			data_o = data_i;
		end else begin
			data_o = mem[addr_i[7:0]];
		end
	end
endmodule : emb_mem_model

// [tb/testbench.sv]
// Self-checking bench for the external bus and breakpoint block.
// Assumes emb_mem_model on the data pins and a 40 MHz core clock.
`timescale 1ns/1ps
`include "emb_params.svh"
module testbench;
	import emb_pkg::*;
	logic clk_i = 1'b0; // Core clock
	logic rst_i = 1'b1; // Synchronous reset
	logic [15:0] addr = 16'h0000; // Core address
	logic [7:0] wdata = 8'h00; // Core write data
	logic rd = 1'b0, wr = 1'b0, fe = 1'b0, onchip = 1'b0, susp = 1'b0, sel_ext = 1'b0; // Core controls
	logic [7:0] wb_adr = 8'h00; // Register bus request
	logic [31:0] wb_dat = 32'h0, wb_do, q;
	logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_ack, ext_oe, cf_n, brk, irq;
	logic [7:0] rdata, ext_do, ext_di;
	logic [15:0] ext_addr;
	int error_cnt = 0; // Mismatches
	int cmp_count = 0; // Comparisons
	int n;
	emb_ext_bus u_dut (.clk_i(clk_i), .rst_i(rst_i), .core_addr_i(addr), .core_wdata_i(wdata), .core_rd_i(rd),
		.core_wr_i(wr), .core_fetch_i(fe), .core_onchip_i(onchip), .suspend_i(susp),
		.external_code_select_i(sel_ext), .core_rdata_o(rdata), .ext_addr_o(ext_addr), .ext_data_i(ext_di),
		.ext_data_o(ext_do), .ext_data_oe_o(ext_oe), .code_fetch_n_o(cf_n), .brk_out_o(brk), .irq_o(irq),
		.wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_we_i(wb_we), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_dat_o(wb_do), .wb_ack_o(wb_ack));
	emb_mem_model u_mem (.clk_i(clk_i), .addr_i(ext_addr), .data_i(ext_do), .oe_i(ext_oe), .data_o(ext_di));
	// Clock generator
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// Count and report one comparison
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : chk
	// Classic single Wishbone cycle, held until ack
	task automatic wbc(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		k = 0;
		// Wait for ack however long it takes; only the watchdog ends a hang
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack !== 1'b1);
		q = wb_do;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		chk(k == 2, "ack not one cycle after request");
	endtask : wbc
	// One core cycle, then idle; returns just after the pins update
	task automatic cyc(input logic r, w, f, o, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		rd <= r;
		wr <= w;
		fe <= f;
		onchip <= o;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
		rd <= 1'b0;
		wr <= 1'b0;
		fe <= 1'b0;
		#1;
	endtask : cyc
	// Writes, on-chip access, reads and suspend on the data pins
	task automatic t_bus();
		cyc(1'b0, 1'b1, 1'b0, 1'b0, 16'h1234, 8'h3C);
		chk(ext_addr === 16'h1234 && ext_oe === 1'b1 && ext_do === 8'h3C, "ext write");
		@(posedge clk_i) #1;
		chk(ext_oe === 1'b0, "bus not released");
		cyc(1'b0, 1'b1, 1'b0, 1'b1, 16'h0077, 8'hFF);
		chk(ext_oe === 1'b0 && ext_addr === 16'h0077, "on-chip access");
		cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'h1234, 8'h00);
		chk(ext_oe === 1'b0 && cf_n === 1'b1, "ext read");
		@(posedge clk_i) #1;
		chk(rdata === 8'h3C, "read data");
		@(posedge clk_i);
		susp <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk(ext_oe === 1'b1 && ext_do === 8'h00 && cf_n === 1'b1, "suspend level");
		@(posedge clk_i);
		susp <= 1'b0;
	endtask : t_bus
	// Fetch strobe for both select levels at the range boundary
	task automatic t_fetch();
		logic [15:0] a;
		for (int i = 0; i < 4; i++) begin
			a = i[0] ? 16'h4000 : 16'h3FFF;
			@(posedge clk_i);
			sel_ext <= i[1];
			cyc(1'b0, 1'b0, 1'b1, 1'b0, a, 8'h00);
			chk(cf_n === !(i[1] || i[0]), "fetch strobe");
			@(posedge clk_i) #1;
			if (i != 0) chk(rdata === (a[7:0] ^ 8'h5A), "fetch data");
		end
	endtask : t_fetch
	// Pulse, latch, masked interrupt and disabled breakpoint
	task automatic t_brk();
		wbc(1'b1, 8'h04, 32'h2345);
		wbc(1'b1, 8'h10, 32'h1);
		wbc(1'b1, 8'h00, 32'h6);
		cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'h2345, 8'h00);
		n = 0;
		repeat (12) begin
			if (brk === 1'b1) n++;
			@(posedge clk_i) #1;
		end
		chk(n == 8, "pulse length");
		wbc(1'b1, 8'h0C, 32'h1);
		wbc(1'b1, 8'h00, 32'h3);
		repeat (2) @(posedge clk_i);
		#1;
		chk(brk === 1'b0 && irq === 1'b0, "cleared idle");
		cyc(1'b0, 1'b1, 1'b0, 1'b0, 16'h2345, 8'h11);
		repeat (10) @(posedge clk_i);
		#1;
		chk(brk === 1'b1 && irq === 1'b1, "latched");
		wbc(1'b0, 8'h08, 32'h0);
		chk(q[0] === 1'b1, "irq status");
		wbc(1'b1, 8'h00, 32'h3);
		repeat (2) @(posedge clk_i);
		#1;
		chk(brk === 1'b0, "latch cleared");
		wbc(1'b1, 8'h0C, 32'h1);
		wbc(1'b1, 8'h10, 32'h0);
		cyc(1'b0, 1'b0, 1'b1, 1'b0, 16'h2345, 8'h00);
		repeat (3) @(posedge clk_i);
		#1;
		chk(brk === 1'b1 && irq === 1'b0, "masked irq");
		wbc(1'b1, 8'h00, 32'h1);
		cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'h2345, 8'h00);
		repeat (3) @(posedge clk_i);
		#1;
		chk(brk === 1'b0, "disabled");
		wbc(1'b0, 8'h20, 32'h0);
		chk(q === 32'h0, "unmapped read");
	endtask : t_brk
	// Print the verdict and stop
	task automatic end_of_test();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	// Watchdog against a hung handshake
	initial begin
		repeat (3000) @(posedge clk_i);
		error_cnt++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk(ext_addr === 16'h0 && ext_oe === 1'b0 && cf_n === 1'b1 && brk === 1'b0 && irq === 1'b0, "reset");
		t_bus();
		t_fetch();
		t_brk();
		end_of_test();
	end
endmodule : testbench

// [verilog/emb_ext_bus.sv]
// External code/data memory bus of the core, with the address breakpoint unit.
// Assumes core strobes synchronous to clk_i and a classic Wishbone master.
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "emb_params.svh"
module emb_ext_bus
	import emb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] core_addr_i,
	input wire logic [7:0] core_wdata_i,
	input wire logic core_rd_i,
	input wire logic core_wr_i,
	input wire logic core_fetch_i,
	input wire logic core_onchip_i,
	input wire logic suspend_i,
	input wire logic external_code_select_i,
	output logic [7:0] core_rdata_o,
	output logic [15:0] ext_addr_o,
	input wire logic [7:0] ext_data_i,
	output logic [7:0] ext_data_o,
	output logic ext_data_oe_o,
	output logic code_fetch_n_o,
	output logic brk_out_o,
	output logic irq_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	// True when a fetch at this address goes to external program memory
	// Below the base, code comes from on-chip RAM unless the select input is high
	function automatic logic is_ext_code(input logic [15:0] addr, input logic sel);
		is_ext_code = sel || (addr >= `EMB_EXT_CODE_BASE);
	endfunction : is_ext_code

	// External bus state
	emb_cyc_t cyc_kind; // Cycle presented on the pins
	emb_cyc_t next_cyc_kind;
	logic [15:0] next_ext_addr;
	logic [7:0] next_ext_data;
	logic next_ext_data_oe;
	logic next_code_fetch_n;
	logic [7:0] next_core_rdata;

	// Breakpoint and register state
	logic brk_status; // Sticky breakpoint hit
	logic brk_enable; // Breakpoints armed
	logic brk_pulse_mode; // 1: fixed pulse, 0: latch
	logic [15:0] brk_match_addr; // Address to compare
	logic [3:0] pulse_cnt; // Clocks of pulse left
	logic match_q; // Match seen last cycle
	logic [1:0] irq_status; // Sticky events
	logic [1:0] irq_enable; // Event mask
	logic next_brk_status, next_brk_enable, next_brk_pulse_mode, next_match_q;
	logic [15:0] next_brk_match_addr;
	logic [3:0] next_pulse_cnt;
	logic [1:0] next_irq_status, next_irq_enable;
	logic next_brk_out, next_irq;
	logic [31:0] next_wb_dat;
	logic next_wb_ack;

	// Decoded helpers
	logic access; // Core drives a valid address
	logic match; // Enabled address match
	logic match_rise; // First cycle of a match
	logic wr_en; // Register write at ack edge
	logic [31:0] rd_word; // Register read mux

	// External bus next-state logic
	always_comb begin
		next_cyc_kind = EMB_IDLE;
		if (core_fetch_i && is_ext_code(core_addr_i, external_code_select_i)) begin
			next_cyc_kind = EMB_FETCH;
		end else if (core_rd_i && !core_onchip_i) begin
			next_cyc_kind = EMB_READ;
		end else if (core_wr_i && !core_onchip_i) begin
			next_cyc_kind = EMB_WRITE;
		end
		next_ext_addr = core_addr_i;
		next_code_fetch_n = !(next_cyc_kind == EMB_FETCH) || suspend_i;
		if (suspend_i) begin
			// Lines driven low so nothing floats while asleep
			next_ext_data = 8'h00;
			next_ext_data_oe = 1'b1;
		end else if (next_cyc_kind == EMB_WRITE) begin
			next_ext_data = core_wdata_i;
			next_ext_data_oe = 1'b1;
		end else begin
			// Reads and idle leave the bus to the memory
			next_ext_data = 8'h00;
			next_ext_data_oe = 1'b0;
		end
		// Read data is sampled while the read stands on the pins
		if (cyc_kind == EMB_READ || cyc_kind == EMB_FETCH) begin
			next_core_rdata = ext_data_i;
		end else begin
			next_core_rdata = core_rdata_o;
		end
	end

	// External bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_kind <= EMB_IDLE;
			ext_addr_o <= 16'h0000;
			ext_data_o <= 8'h00;
			ext_data_oe_o <= 1'b0;
			code_fetch_n_o <= 1'b1;
			core_rdata_o <= 8'h00;
		end else begin
			cyc_kind <= next_cyc_kind;
			ext_addr_o <= next_ext_addr;
			ext_data_o <= next_ext_data;
			ext_data_oe_o <= next_ext_data_oe;
			code_fetch_n_o <= next_code_fetch_n;
			core_rdata_o <= next_core_rdata;
		end
	end

	// Register decode helpers
	assign access = core_fetch_i || core_rd_i || core_wr_i;
	// Only cycles that really address memory can hit, so an address bus
	// parked on the match value does not keep raising the pin
	assign match = brk_enable && access && (core_addr_i == brk_match_addr);
	assign match_rise = match && !match_q;
	// Writes land at the edge where ack is already high, so a request that
	// the master holds until then is applied exactly once
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (wb_adr_i)
			`EMB_OFS_BRK_CONTROL: begin
				rd_word[`EMB_BIT_BRK_STATUS] = brk_status;
				rd_word[`EMB_BIT_BRK_ENABLE] = brk_enable;
				rd_word[`EMB_BIT_BRK_PULSE_MODE] = brk_pulse_mode;
			end
			`EMB_OFS_BRK_MATCH_ADDR: rd_word[15:0] = brk_match_addr;
			`EMB_OFS_IRQ_STATUS: rd_word[1:0] = irq_status;
			`EMB_OFS_IRQ_ENABLE: rd_word[1:0] = irq_enable;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Breakpoint, register and bus-slave next-state logic
	always_comb begin
		next_match_q = match;
		next_brk_enable = brk_enable;
		next_brk_pulse_mode = brk_pulse_mode;
		next_brk_match_addr = brk_match_addr;
		next_irq_enable = irq_enable;
		next_brk_status = brk_status;
		next_irq_status = irq_status;
		if (wr_en) begin
			case (wb_adr_i)
				`EMB_OFS_BRK_CONTROL: begin
					next_brk_enable = wb_dat_i[`EMB_BIT_BRK_ENABLE];
					next_brk_pulse_mode = wb_dat_i[`EMB_BIT_BRK_PULSE_MODE];
					// Writing one clears the hit flag
					if (wb_dat_i[`EMB_BIT_BRK_STATUS]) begin
						next_brk_status = 1'b0;
					end
				end
				`EMB_OFS_BRK_MATCH_ADDR: begin
					next_brk_match_addr[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) begin
						next_brk_match_addr[15:8] = wb_dat_i[15:8];
					end
				end
				`EMB_OFS_IRQ_CLEAR: next_irq_status = irq_status & ~wb_dat_i[1:0];
				`EMB_OFS_IRQ_ENABLE: next_irq_enable = wb_dat_i[1:0];
				default: next_irq_enable = irq_enable;
			endcase
		end
		// A new hit beats a clear in the same cycle
		if (match) begin
			next_brk_status = 1'b1;
		end
		if (match_rise) begin
			next_irq_status[`EMB_BIT_IRQ_BRK] = 1'b1;
		end
		if (next_cyc_kind != EMB_IDLE && cyc_kind == EMB_IDLE) begin
			next_irq_status[`EMB_BIT_IRQ_EXT] = 1'b1;
		end
		// Pulse counter restarts on every new match
		if (match_rise) begin
			next_pulse_cnt = `EMB_BRK_PULSE_CLKS;
		end else if (pulse_cnt != 4'h0) begin
			next_pulse_cnt = pulse_cnt - 4'h1;
		end else begin
			next_pulse_cnt = 4'h0;
		end
		if (next_brk_pulse_mode) begin
			next_brk_out = (next_pulse_cnt != 4'h0);
		end else begin
			next_brk_out = next_brk_status;
		end
		next_irq = |(next_irq_status & next_irq_enable);
		// Ack is a one-cycle pulse; it drops even while the master keeps stb high
		next_wb_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_wb_dat = next_wb_ack ? rd_word : 32'h0000_0000;
	end

	// Breakpoint, register and bus-slave registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brk_status <= 1'b0;
			brk_enable <= 1'b0;
			brk_pulse_mode <= 1'b0;
			brk_match_addr <= `EMB_RST_MATCH_ADDR;
			pulse_cnt <= 4'h0;
			match_q <= 1'b0;
			irq_status <= 2'h0;
			irq_enable <= `EMB_RST_IRQ_ENABLE;
			brk_out_o <= 1'b0;
			irq_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
		end else begin
			brk_status <= next_brk_status;
			brk_enable <= next_brk_enable;
			brk_pulse_mode <= next_brk_pulse_mode;
			brk_match_addr <= next_brk_match_addr;
			pulse_cnt <= next_pulse_cnt;
			match_q <= next_match_q;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			brk_out_o <= next_brk_out;
			irq_o <= next_irq;
			wb_dat_o <= next_wb_dat;
			wb_ack_o <= next_wb_ack;
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Pin behaviour of the external bus
	a_addr_follows: assert property (##1 ext_addr_o == $past(core_addr_i))
		else $error("address pins do not follow core address");
	a_bus_floats: assert property (!suspend_i && !(core_wr_i && !core_onchip_i) |=> !ext_data_oe_o)
		else $error("data bus driven outside a write");
	a_write_drives: assert property (!suspend_i && core_wr_i && !core_onchip_i && !core_fetch_i && !core_rd_i
		|=> ext_data_oe_o && ext_data_o == $past(core_wdata_i))
		else $error("external write not driven");
	a_onchip_quiet: assert property (!suspend_i && core_onchip_i && !core_fetch_i |=> !ext_data_oe_o)
		else $error("data bus enabled for on-chip access");
	a_suspend_low: assert property (suspend_i |=> ext_data_oe_o && ext_data_o == 8'h00)
		else $error("data bus not low in suspend");
	a_fetch_only: assert property (!core_fetch_i |=> code_fetch_n_o)
		else $error("fetch strobe on a data access");
	a_fetch_range: assert property (core_fetch_i && !suspend_i
		|=> code_fetch_n_o == !($past(external_code_select_i) || $past(core_addr_i) >= `EMB_EXT_CODE_BASE))
		else $error("fetch strobe wrong for address range");
	// Breakpoint pin behaviour
	a_match_high: assert property (match && !(wr_en && brk_pulse_mode != wb_dat_i[2]) |=> brk_out_o)
		else $error("breakpoint not raised on match");
	// Window ends on the eighth clock of the pulse: high there and at its start, low next
	a_pulse_eight: assert property (match_rise && brk_pulse_mode && !wr_en ##1 (brk_pulse_mode && !match)[*8]
		|-> (brk_out_o && $past(brk_out_o, 7)) ##1 !brk_out_o)
		else $error("breakpoint pulse not eight clocks");
	a_latch_hold: assert property (brk_out_o && !brk_pulse_mode && !wr_en |=> brk_out_o)
		else $error("latched breakpoint dropped without clear");
	// A hit in the same cycle as a clear must survive
	a_status_set: assert property (match |=> brk_status)
		else $error("breakpoint hit lost");
	// Read data is the pin value of the cycle in which the read stood
	a_rdata_capture: assert property ((cyc_kind == EMB_READ || cyc_kind == EMB_FETCH)
		|=> core_rdata_o == $past(ext_data_i))
		else $error("read data not taken from the pins");
	a_suspend_strobe: assert property (suspend_i |=> code_fetch_n_o)
		else $error("fetch strobe active in suspend");
	// Checked while reset is applied, so the default disable is overridden
	a_reset_idle: assert property (disable iff (1'b0) rst_i |=> ext_addr_o == 16'h0000 && !ext_data_oe_o
		&& code_fetch_n_o && !brk_out_o)
		else $error("pins not idle after reset");

	// Main scenarios reached by the bench
	c_ext_fetch: cover property (!code_fetch_n_o);
	c_pulse: cover property (match_rise && brk_pulse_mode ##1 brk_out_o[*8] ##1 !brk_out_o);
	c_latch_clear: cover property (brk_out_o && !brk_pulse_mode ##1 wr_en ##2 !brk_out_o);
	c_suspend: cover property (suspend_i ##1 ext_data_oe_o);
	c_ext_read: cover property (cyc_kind == EMB_READ);

endmodule : emb_ext_bus
